/* vram_dev_model.sv */
`timescale 1ns/100ps
`default_nettype none
module vram_dev_model #(
  parameter logic [15:0] COLOR = 16'hA5C3,
  parameter int T_ACC_NS = 80
) (
  input wire logic row_strobe_n,
  input wire logic column_strobe_low_byte_n,
  input wire logic column_strobe_high_byte_n,
  input wire logic write_strobe_n,
  input wire logic function_select,
  input wire logic transfer_output_gate_n,
  input wire logic [8:0] address_lines,
  input wire logic [15:0] data_bus,
  input wire logic ctrl_oe,
  output logic [15:0] dev_dq,
  output logic dev_oe,
  output logic clash
);
  logic [15:0] mem [bit [17:0]];
  logic [15:0] wmask_q, row_dq, rd_val, flt;
  logic [8:0] row_a, col_a;
  logic we_row, fs_row, fs_col, persist, done, valid;
  wire cas_n = column_strobe_low_byte_n & column_strobe_high_byte_n;
  initial begin
    {persist, dev_oe, valid, clash, done} = 5'b00001;
    wmask_q = 16'hFFFF;
    flt = 16'h5A5A;
  end
  // a released bus must not keep showing the last value
  always #10 flt = ~flt;
  assign dev_dq = valid ? rd_val : flt;
  always @(negedge row_strobe_n) begin
    {row_a, we_row, fs_row, row_dq} = {address_lines, write_strobe_n, function_select, data_bus};
    // gate low here would start a transfer nobody asked for
    if (!transfer_output_gate_n) clash = 1'b1;
  end
  always @(negedge cas_n) begin
    {col_a, fs_col, done} = {address_lines, function_select, 1'b0};
    if (write_strobe_n && !transfer_output_gate_n) begin
      rd_val = mem.exists({row_a, col_a}) ? mem[{row_a, col_a}] : 16'h0000;
      dev_oe = 1'b1;
      #(T_ACC_NS);
      valid = dev_oe;
    end
  end
  always @(posedge cas_n or posedge transfer_output_gate_n or negedge write_strobe_n) begin
    dev_oe = 1'b0;
    valid = 1'b0;
  end
  always @(posedge ctrl_oe) begin
    #1;
    if (dev_oe) clash = 1'b1;
  end
  // data taken at the later of the two falling strobes
  always @(negedge cas_n or negedge write_strobe_n) begin
    #1;
    if (!row_strobe_n && !cas_n && !write_strobe_n && !done) begin
      done = 1'b1;
      wr_cycle();
    end
  end
  task automatic wr_cycle();
    logic [15:0] m, d, be;
    d = data_bus;
    be = {{8{!column_strobe_high_byte_n}}, {8{!column_strobe_low_byte_n}}};
    if (fs_row && !fs_col && we_row) begin
      wmask_q = d;
      persist = 1'b1;
    end else begin
      m = we_row ? 16'hFFFF : (persist ? wmask_q : row_dq);
      for (int c = 0; c < 4; c++)
        for (int i = 0; i < 16; i++)
          if (m[i] && be[i] && (fs_col ? d[i/4*4+c] : c == col_a[1:0]))
            put({row_a, col_a[8:2], 2'(c)}, i, fs_col ? COLOR[i] : d[i]);
    end
  endtask
  task automatic put(input bit [17:0] k, input int i, input logic v);
    if (!mem.exists(k)) mem[k] = 16'h0000;
    mem[k][i] = v;
  endtask
endmodule
`default_nettype wire

/* vram_host_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RULE_01 - device samples write strobe and data at row fall, data at later strobe fall
// RULE_02 - unmasked write: write strobe high at row fall, data then valid data
// RULE_03 - one-shot masked write: write strobe low, per-I/O mask on data at row fall
// RULE_04 - stored-mask write: write strobe low at row fall, data don't-care
// RULE_05 - completing a mask load puts the device in stored-mask mode
// RULE_06 - mask load: select high at row, low at column, write strobe high at row
// RULE_07 - mask load ignores column address and writes no array location
// RULE_08 - controller sets function select at both row and column strobe falls
// RULE_09 - reads, writes and read-modify-writes may mix within one open row
// RULE_10 - with late writes in page mode keep output gate high throughout
// RULE_11 - early writes only: gate free after its hold time from row fall
// RULE_12 - read-modify-write offers same three write modes and mask-load coding
// RULE_13 - read data is sampled only after the access time
// RULE_14 - unmasked block write: strobe high at row, column mask at column time
// RULE_15 - one-shot masked block write: mask at row, column mask at column time
// RULE_16 - stored-mask block write: strobe low at row, column mask at column time
// RULE_17 - mask bit 0 blocks an I/O, 1 lets it be written
// RULE_18 - block write: each four data lines form one group's column mask
// RULE_19 - group bit offsets 0..3 pick columns with low address bits 00..11
// RULE_20 - block write ignores two low column bits, writes color to enabled columns
// RULE_21 - late write keeps device outputs off for the whole cycle
// RULE_22 - gate turns device outputs off before controller drives data
module vram_host_ctrl
  import vram_host_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic row_strobe_n,
  output logic column_strobe_low_byte_n,
  output logic column_strobe_high_byte_n,
  output logic write_strobe_n,
  output logic function_select,
  output logic transfer_output_gate_n,
  output logic [vram_host_pkg::ADDR_W-1:0] address_lines,
  output logic [vram_host_pkg::DATA_W-1:0] data_lines_o,
  output logic data_lines_oe,
  input wire logic [vram_host_pkg::DATA_W-1:0] data_lines_i
);
  import vram_host_pkg::*;

  // command word spans op, mode, keep and both byte bits
  localparam int CMD_W = BYTE_HI_BIT + 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [3:0] {
    S_IDLE, S_ROW_SET, S_ROW_HOLD, S_COL_SET, S_COL_HOLD, S_LATE_OFF, S_LATE_WR, S_CAS_UP, S_PRECH
  } state_t;

  state_t state_q, state_d;
  logic [TMR_W-1:0] tmr_q;
  logic [CMD_W-1:0] cmd_q;
  logic [ADDR_W-1:0] row_q, col_q;
  logic [DATA_W-1:0] wdata_q, mask_q, rdata_q, data_sync;
  logic row_open_q, persist_q;
  logic ap_wr_q;
  logic [7:0] ap_addr_q;

  // bus decode
  wire ap_take = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
  wire busy = (state_q != S_IDLE);
  wire wr_cmd = ap_wr_q && (ap_addr_q == OFF_CMD);
  wire start = wr_cmd && !busy;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      OFF_CMD: r[CMD_W-1:0] = cmd_q;
      OFF_ROW: r[ADDR_W-1:0] = row_q;
      OFF_COL: r[ADDR_W-1:0] = col_q;
      OFF_WDATA: r[DATA_W-1:0] = wdata_q;
      OFF_MASK: r[DATA_W-1:0] = mask_q;
      OFF_STATUS: begin
        r[ST_BUSY_BIT] = busy;
        r[ST_ROW_OPEN_BIT] = row_open_q;
        r[ST_PERSIST_BIT] = persist_q;
      end
      OFF_RDATA: r[DATA_W-1:0] = rdata_q;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // command in flight, new value while starting
  wire [CMD_W-1:0] cmd_now = start ? hwdata[CMD_W-1:0] : cmd_q;
  wire [2:0] op = cmd_now[CMD_LSB +: 3];
  wire [1:0] wm = cmd_now[WM_LSB +: 2];
  wire keep_row = cmd_q[KEEP_ROW_BIT];
  wire is_load = (op == CMD_LOAD_MASK);
  wire is_block = (op == CMD_BLOCK_WR);
  wire is_read = (op == CMD_READ);
  wire is_rmw = (op == CMD_RMW);
  wire is_late = (op == CMD_LATE_WR);
  wire reads_first = is_read || is_rmw;
  wire masked = (wm == WM_ONCE) || (wm == WM_STORED);
  // levels presented at the row strobe fall
  wire row_we_n = is_load || !masked; // see RULE_02 see RULE_04 see RULE_06 see RULE_12
  wire row_oe = !is_load && (wm == WM_ONCE); // see RULE_03 see RULE_15
  // levels presented at the column strobe fall
  wire col_fs = is_block; // see RULE_08
  wire early = (op == CMD_EARLY_WR) || is_block || is_load;
  // block and mask load carry mask words, not the array data
  wire [DATA_W-1:0] col_data = is_load ? mask_q : wdata_q; // see RULE_14 see RULE_18 see RULE_19
  // mask load ignores the column, present zero there
  wire [ADDR_W-1:0] col_addr = is_load ? '0 : col_q; // see RULE_07 see RULE_20
  wire tmr_done = (tmr_q == '0);
  wire both_bytes = is_load || is_block;
  wire cas_lo = both_bytes || cmd_q[BYTE_LO_BIT];
  wire cas_hi = both_bytes || cmd_q[BYTE_HI_BIT];

  vram_pin_sync #(.WIDTH(DATA_W)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .pin_in(data_lines_i),
    .pin_sync(data_sync)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: if (start) begin
        if (op == CMD_CLOSE) state_d = row_open_q ? S_PRECH : S_IDLE;
        else state_d = row_open_q ? S_COL_SET : S_ROW_SET; // see RULE_09
      end
      S_ROW_SET: if (tmr_done) state_d = S_ROW_HOLD;
      S_ROW_HOLD: if (tmr_done) state_d = S_COL_SET;
      S_COL_SET: if (tmr_done) state_d = S_COL_HOLD;
      S_COL_HOLD: if (tmr_done) state_d = (is_late || is_rmw) ? S_LATE_OFF : S_CAS_UP;
      S_LATE_OFF: if (tmr_done) state_d = S_LATE_WR;
      S_LATE_WR: if (tmr_done) state_d = S_CAS_UP;
      S_CAS_UP: if (tmr_done) state_d = keep_row ? S_IDLE : S_PRECH;
      S_PRECH: if (tmr_done) state_d = S_IDLE;
    endcase
  end

  // bus side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      ap_wr_q <= ap_take && hwrite;
      ap_addr_q <= haddr[7:0];
      if (ap_take && !hwrite) hrdata <= rd_mux(haddr[7:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row_q <= '0;
      col_q <= '0;
      wdata_q <= '0;
      mask_q <= '0;
    end else if (ce && ap_wr_q) begin
      if (ap_addr_q == OFF_ROW) row_q <= hwdata[ADDR_W-1:0];
      if (ap_addr_q == OFF_COL) col_q <= hwdata[ADDR_W-1:0];
      if (ap_addr_q == OFF_WDATA) wdata_q <= hwdata[DATA_W-1:0];
      // bit 0 blocks an I/O, 1 lets it through
      if (ap_addr_q == OFF_MASK) mask_q <= hwdata[DATA_W-1:0]; // see RULE_17
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= S_IDLE;
      tmr_q <= '0;
      cmd_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      if (start) cmd_q <= hwdata[CMD_W-1:0];
      if (state_d != state_q) begin
        unique case (state_d)
          S_ROW_HOLD: tmr_q <= CYC_ROW_HOLD;
          S_COL_HOLD: tmr_q <= reads_first ? CYC_ACCESS : CYC_COL_HOLD; // see RULE_13
          S_LATE_WR: tmr_q <= CYC_COL_HOLD;
          S_PRECH: tmr_q <= CYC_PRECH;
          default: tmr_q <= CYC_SETUP;
        endcase
      end else if (!tmr_done) begin
        tmr_q <= tmr_q - TMR_W'(1);
      end
    end
  end

  // mirror of the device's mask mode and open row
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row_open_q <= 1'b0;
      persist_q <= 1'b0;
      rdata_q <= '0;
    end else if (ce) begin
      if (state_q == S_CAS_UP && tmr_done) row_open_q <= keep_row;
      if (state_q == S_PRECH && tmr_done) row_open_q <= 1'b0;
      if (state_q == S_CAS_UP && tmr_done && is_load) persist_q <= 1'b1; // see RULE_05
      // synced bus sampled only once access time plus sync delay is over
      if (state_q == S_COL_HOLD && tmr_done && reads_first) rdata_q <= data_sync; // see RULE_13
    end
  end

  // pin drive, all straight from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row_strobe_n <= 1'b1;
      column_strobe_low_byte_n <= 1'b1;
      column_strobe_high_byte_n <= 1'b1;
      write_strobe_n <= 1'b1;
      function_select <= 1'b0;
      transfer_output_gate_n <= 1'b1;
      address_lines <= '0;
      data_lines_o <= '0;
      data_lines_oe <= 1'b0;
    end else if (ce && state_d != state_q) begin
      unique case (state_d)
        S_ROW_SET: begin
          // gate low at row fall would start a transfer
          transfer_output_gate_n <= 1'b1; // see RULE_11
          address_lines <= row_q;
          function_select <= is_load; // see RULE_06 see RULE_08
          write_strobe_n <= row_we_n; // see RULE_01
          data_lines_o <= mask_q; // see RULE_03 see RULE_15
          data_lines_oe <= row_oe;
        end
        S_ROW_HOLD: row_strobe_n <= 1'b0;
        S_COL_SET: begin
          address_lines <= col_addr;
          function_select <= col_fs; // see RULE_06 see RULE_08
          write_strobe_n <= !early;
          // gate drops only after its hold from row fall, covered by row hold
          transfer_output_gate_n <= !reads_first; // see RULE_11
          data_lines_o <= col_data; // see RULE_14 see RULE_16
          data_lines_oe <= early;
        end
        S_COL_HOLD: begin
          column_strobe_low_byte_n <= !cas_lo;
          column_strobe_high_byte_n <= !cas_hi;
        end
        S_LATE_OFF: begin
          // outputs off before the bus is driven
          transfer_output_gate_n <= 1'b1; // see RULE_22 see RULE_21
        end
        S_LATE_WR: begin
          data_lines_o <= wdata_q; // see RULE_12
          data_lines_oe <= 1'b1;
          write_strobe_n <= 1'b0;
        end
        S_CAS_UP: begin
          column_strobe_low_byte_n <= 1'b1;
          column_strobe_high_byte_n <= 1'b1;
          write_strobe_n <= 1'b1;
          data_lines_oe <= 1'b0;
          // stays high between commands while the row is open
          transfer_output_gate_n <= 1'b1; // see RULE_10
        end
        S_PRECH: row_strobe_n <= 1'b1;
        default: data_lines_oe <= 1'b0;
      endcase
    end
  end

  // cycles since the row strobe fell, saturating so long open rows do not wrap
  logic [TMR_W-1:0] row_age_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row_age_q <= '0;
    end else if (ce) begin
      if (row_strobe_n) row_age_q <= '0;
      else if (row_age_q != '1) row_age_q <= row_age_q + TMR_W'(1);
    end
  end

  wire cas_any_n = column_strobe_low_byte_n & column_strobe_high_byte_n;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_gate_row_fall: assert property ($fell(row_strobe_n) |-> transfer_output_gate_n) // see RULE_11
    else $error("gate low at row strobe fall");
  chk_plain_row_we: assert property ($fell(row_strobe_n) && !is_load && wm == WM_PLAIN |-> write_strobe_n) // see RULE_02
    else $error("unmasked write with write strobe low at row fall");
  chk_once_mask_row: assert property ($fell(row_strobe_n) && !is_load && wm == WM_ONCE // see RULE_03
    |-> !write_strobe_n && data_lines_oe && data_lines_o == mask_q)
    else $error("one-shot mask missing at row fall");
  chk_stored_mask_row: assert property ($fell(row_strobe_n) && !is_load && wm == WM_STORED // see RULE_04
    |-> !write_strobe_n && !data_lines_oe)
    else $error("stored-mask write drove data at row fall");
  chk_load_encoding: assert property ($fell(row_strobe_n) && is_load // see RULE_06
    |-> function_select && write_strobe_n && !data_lines_oe)
    else $error("mask load not encoded at row fall");
  chk_load_col_fs: assert property ($fell(cas_any_n) && is_load |-> !function_select && address_lines == '0) // see RULE_07
    else $error("mask load column select or address wrong");
  chk_block_col_mask: assert property ($fell(cas_any_n) && is_block // see RULE_14
    |-> function_select && data_lines_oe && data_lines_o == wdata_q)
    else $error("block write column mask not on bus");
  chk_oe_gate_off: assert property (data_lines_oe |-> transfer_output_gate_n) // see RULE_22
    else $error("data driven while device outputs enabled");
  chk_persist_cause: assert property ($rose(persist_q) |-> $past(is_load) && $past(state_q) == S_CAS_UP) // see RULE_05
    else $error("stored-mask mode set without mask load");
  chk_read_wait: assert property ($fell(cas_any_n) && reads_first |-> cas_any_n == 1'b0 [*4]) // see RULE_13
    else $error("column strobe released before access time");
  chk_row_addr_fall: assert property ($fell(row_strobe_n) |-> address_lines == row_q)
    else $error("row address not held at row strobe fall");
  chk_col_addr_fall: assert property ($fell(cas_any_n) && !is_load |-> address_lines == col_q) // see RULE_20
    else $error("column address wrong at column strobe fall");
  chk_late_we_data: assert property ($fell(write_strobe_n) && !row_strobe_n && !cas_any_n // see RULE_01
    |-> data_lines_oe && data_lines_o == wdata_q)
    else $error("late write strobe fell without write data");
  chk_late_dev_off: assert property (state_q == S_LATE_WR |-> transfer_output_gate_n) // see RULE_21
    else $error("device outputs enabled during late write");
  chk_page_gate_high: assert property (row_open_q && state_q == S_IDLE |-> transfer_output_gate_n) // see RULE_10
    else $error("gate low while page is held open");
  chk_block_both_bytes: assert property ($fell(cas_any_n) && (is_block || is_load) // see RULE_18
    |-> !column_strobe_low_byte_n && !column_strobe_high_byte_n)
    else $error("block write or mask load missed a byte strobe");
  chk_rdata_after_access: assert property ($changed(rdata_q) // see RULE_13
    |-> $past(state_q) == S_COL_HOLD && $past(reads_first))
    else $error("read data taken outside the access window");
  chk_gate_hold_row: assert property ($fell(transfer_output_gate_n) && !row_strobe_n // see RULE_11
    |-> row_age_q >= CYC_ROW_HOLD)
    else $error("gate dropped before its hold after row fall");

  cov_block_write: cover property ($fell(cas_any_n) && is_block);
  cov_mask_load: cover property ($rose(persist_q));
  cov_late_write: cover property (state_q == S_LATE_WR && is_late);
  cov_page_hit: cover property (start && row_open_q && op != CMD_CLOSE);
  cov_rmw_cycle: cover property (state_q == S_LATE_WR && is_rmw);
endmodule
`default_nettype wire

/* vram_host_pkg.sv */
`default_nettype none
package vram_host_pkg;
  localparam int CLK_NS = 20;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int TMR_W = 8;
  localparam int SYNC_LAT = 2;

  // register offsets, byte addresses
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ROW = 8'h04;
  localparam logic [7:0] OFF_COL = 8'h08;
  localparam logic [7:0] OFF_WDATA = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_RDATA = 8'h18;

  // command register fields
  localparam int CMD_LSB = 0;
  localparam int WM_LSB = 4;
  localparam int KEEP_ROW_BIT = 8;
  localparam int BYTE_LO_BIT = 9;
  localparam int BYTE_HI_BIT = 10;

  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_EARLY_WR = 3'h1;
  localparam logic [2:0] CMD_LATE_WR = 3'h2;
  localparam logic [2:0] CMD_RMW = 3'h3;
  localparam logic [2:0] CMD_LOAD_MASK = 3'h4;
  localparam logic [2:0] CMD_BLOCK_WR = 3'h5;
  localparam logic [2:0] CMD_CLOSE = 3'h6;

  localparam logic [1:0] WM_PLAIN = 2'h0;
  localparam logic [1:0] WM_ONCE = 2'h1;
  localparam logic [1:0] WM_STORED = 2'h2;

  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ROW_OPEN_BIT = 1;
  localparam int ST_PERSIST_BIT = 2;

  // strobe timing in ns, plain defaults
  localparam int T_SETUP_NS = 20;
  localparam int T_ROW_HOLD_NS = 40;
  localparam int T_GATE_HOLD_NS = 20;
  localparam int T_COL_HOLD_NS = 40;
  localparam int T_ACCESS_NS = 80;
  localparam int T_PRECH_NS = 60;

  function automatic logic [TMR_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1) c = 1;
    return TMR_W'(c);
  endfunction

  localparam logic [TMR_W-1:0] CYC_SETUP = ns_to_cyc(T_SETUP_NS);
  localparam logic [TMR_W-1:0] CYC_ROW_HOLD =
    ns_to_cyc(T_ROW_HOLD_NS > T_GATE_HOLD_NS ? T_ROW_HOLD_NS : T_GATE_HOLD_NS);
  localparam logic [TMR_W-1:0] CYC_COL_HOLD = ns_to_cyc(T_COL_HOLD_NS);
  localparam logic [TMR_W-1:0] CYC_ACCESS = ns_to_cyc(T_ACCESS_NS) + TMR_W'(SYNC_LAT);
  localparam logic [TMR_W-1:0] CYC_PRECH = ns_to_cyc(T_PRECH_NS);
endpackage
`default_nettype wire

/* vram_pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module vram_pin_sync #(
  parameter int WIDTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      pin_sync <= '0;
    end else if (ce) begin
      meta_q <= pin_in;
      pin_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* vram_write_mode_cycle_decode_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module vram_write_mode_cycle_decode_tb_top;
  import vram_host_pkg::*;
  localparam logic [15:0] COLOR = 16'h3C96;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ras_n, cas_lo_n, cas_hi_n, wr_n, fsel, gate_n;
  logic d_oe, dev_oe, clash;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [8:0] addr;
  logic [15:0] d_o, dev_dq, e_wmask;
  wire logic [15:0] dq = d_oe ? d_o : dev_dq;
  int fail_count, total_checks;
  logic [15:0] exp_mem [bit [17:0]];
  bit e_persist;
  vram_host_ctrl i_vram_host_ctrl (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .row_strobe_n(ras_n),
    .column_strobe_low_byte_n(cas_lo_n), .column_strobe_high_byte_n(cas_hi_n), .write_strobe_n(wr_n),
    .function_select(fsel), .transfer_output_gate_n(gate_n), .address_lines(addr), .data_lines_o(d_o),
    .data_lines_oe(d_oe), .data_lines_i(dq));
  vram_dev_model #(.COLOR(COLOR), .T_ACC_NS(T_ACCESS_NS)) i_vram_dev_model (.row_strobe_n(ras_n),
    .column_strobe_low_byte_n(cas_lo_n), .column_strobe_high_byte_n(cas_hi_n), .write_strobe_n(wr_n),
    .function_select(fsel), .transfer_output_gate_n(gate_n), .address_lines(addr), .data_bus(dq),
    .ctrl_oe(d_oe), .dev_dq(dev_dq), .dev_oe(dev_oe), .clash(clash));
  initial begin
    hclk = 1'b0;
    forever #(CLK_NS/2) hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic ahb(input bit wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready_s() !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready_s() !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  function automatic logic hready_s();
    return hreadyout;
  endfunction
  function automatic logic [15:0] eget(input bit [17:0] k);
    return exp_mem.exists(k) ? exp_mem[k] : 16'h0000;
  endfunction
  task automatic op(input logic [2:0] c, input logic [1:0] wm, input bit keep, input logic [1:0] by,
                    input logic [8:0] r, input logic [8:0] cl, input logic [15:0] wd, input logic [15:0] mk);
    logic [31:0] st;
    logic [15:0] m;
    int n;
    ahb(1'b1, OFF_ROW, 32'(r), st);
    ahb(1'b1, OFF_COL, 32'(cl), st);
    ahb(1'b1, OFF_WDATA, 32'(wd), st);
    ahb(1'b1, OFF_MASK, 32'(mk), st);
    ahb(1'b1, OFF_CMD, 32'(c) << CMD_LSB | 32'(wm) << WM_LSB | 32'(keep) << KEEP_ROW_BIT | 32'(by) << BYTE_LO_BIT, st);
    n = 0;
    do begin
      ahb(1'b0, OFF_STATUS, 32'h0, st);
      if (n == 0) chk("busy_set", 32'h1, 32'(st[ST_BUSY_BIT]));
      n++;
    end while (st[ST_BUSY_BIT] !== 1'b0 && n < 100);
    chk("busy_done", 32'h0, 32'(st[ST_BUSY_BIT]));
    if (c == CMD_LOAD_MASK) begin
      e_wmask = mk;
      e_persist = 1'b1;
    end else if (c != CMD_READ && c != CMD_CLOSE) begin
      m = (wm == WM_ONCE || wm == WM_STORED) ? (e_persist ? e_wmask : mk) : 16'hFFFF;
      for (int k = 0; k < 4; k++)
        for (int i = 0; i < 16; i++)
          if (m[i] && (c == CMD_BLOCK_WR ? wd[i/4*4+k] : k == cl[1:0] && by[i/8]))
            exp_mem[{r, cl[8:2], 2'(k)}] = eget({r, cl[8:2], 2'(k)}) & ~(16'h1 << i) |
              16'((c == CMD_BLOCK_WR ? COLOR[i] : wd[i])) << i;
    end
  endtask
  task automatic rd_chk(input logic [8:0] r, input logic [8:0] cl, input bit keep);
    logic [31:0] v;
    op(CMD_READ, WM_PLAIN, keep, 2'b11, r, cl, 16'h0000, 16'h0000);
    ahb(1'b0, OFF_RDATA, 32'h0, v);
    chk("rdata", {16'h0000, eget({r, cl})}, v);
  endtask
  task automatic wr_rnd(input logic [2:0] c, input logic [1:0] wm, input logic [1:0] by);
    logic [8:0] r, cl;
    r = 9'($urandom);
    cl = 9'($urandom);
    op(c, wm, 1'b0, by, r, cl, 16'($urandom), 16'($urandom));
    for (int k = 0; k < 4; k++)
      if (c == CMD_BLOCK_WR || k == cl[1:0]) rd_chk(r, {cl[8:2], 2'(k)}, 1'b0);
  endtask
  initial begin
    #(CLK_NS * 40000);
    fail_count++;
    $display("[ERR] watchdog expected done seen timeout");
    finish_test();
  end
  initial begin
    logic [31:0] v;
    logic [2:0] ops [3] = '{CMD_EARLY_WR, CMD_LATE_WR, CMD_RMW};
    logic [8:0] r, cl;
    void'($urandom(32'h8721EE47));
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    fail_count = 0;
    total_checks = 0;
    e_wmask = 16'hFFFF;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, OFF_STATUS, 32'h0, v);
    chk("status_rst", 32'h0, v);
    ahb(1'b0, OFF_RDATA, 32'h0, v);
    chk("rdata_rst", 32'h0, v);
    ahb(1'b0, 8'h1C, 32'h0, v);
    chk("unmapped", 32'h0, v);
    chk("hresp", 32'h0, 32'(hresp));
    foreach (ops[j]) wr_rnd(ops[j], WM_PLAIN, 2'b11);
    foreach (ops[j]) wr_rnd(ops[j], WM_ONCE, 2'b11);
    wr_rnd(CMD_EARLY_WR, WM_PLAIN, 2'b01);
    wr_rnd(CMD_LATE_WR, WM_PLAIN, 2'b10);
    wr_rnd(CMD_BLOCK_WR, WM_PLAIN, 2'b11);
    wr_rnd(CMD_BLOCK_WR, WM_ONCE, 2'b11);
    r = 9'($urandom);
    cl = 9'($urandom);
    op(CMD_EARLY_WR, WM_PLAIN, 1'b0, 2'b11, r, cl, 16'($urandom), 16'h0000);
    op(CMD_LOAD_MASK, WM_PLAIN, 1'b0, 2'b11, r, cl, 16'h0000, 16'($urandom));
    ahb(1'b0, OFF_STATUS, 32'h0, v);
    chk("persist", 32'h1, 32'(v[ST_PERSIST_BIT]));
    rd_chk(r, cl, 1'b0);
    rd_chk(r, 9'h000, 1'b0);
    foreach (ops[j]) wr_rnd(ops[j], WM_STORED, 2'b11);
    wr_rnd(CMD_BLOCK_WR, WM_STORED, 2'b11);
    cl = 9'($urandom);
    op(CMD_EARLY_WR, WM_PLAIN, 1'b1, 2'b11, r, cl, 16'($urandom), 16'h0000);
    rd_chk(r, cl, 1'b1);
    op(CMD_RMW, WM_PLAIN, 1'b1, 2'b11, r, cl ^ 9'h001, 16'($urandom), 16'h0000);
    ahb(1'b0, OFF_STATUS, 32'h0, v);
    chk("row_open", 32'h1, 32'(v[ST_ROW_OPEN_BIT]));
    op(CMD_LATE_WR, WM_PLAIN, 1'b1, 2'b11, r, cl, 16'($urandom), 16'h0000);
    op(CMD_CLOSE, WM_PLAIN, 1'b0, 2'b11, r, cl, 16'h0000, 16'h0000);
    ahb(1'b0, OFF_STATUS, 32'h0, v);
    chk("row_closed", 32'h0, 32'(v[ST_ROW_OPEN_BIT]));
    rd_chk(r, cl, 1'b0);
    rd_chk(r, cl ^ 9'h001, 1'b0);
    chk("bus_clash", 32'h0, 32'(clash));
    finish_test();
  end
endmodule
`default_nettype wire
